// ===== hdl/smdpi_core.v
`timescale 1ns/1ps
`include "smdpi_defines.vh"
// ****************************************************************
// Signed multiply, signed divide and port input datapath.
// ****************************************************************
module smdpi_core
(
	input  wire        CLK_I,
	input  wire        RESET_N_I,
	input  wire        START_I,
	input  wire [1:0]  OP_I,
	input  wire        WORD_I,
	input  wire        PORT_IMM_I,
	input  wire [7:0]  PORT_IMM8_I,
	input  wire [15:0] SRC_I,
	input  wire [15:0] ACC_I,
	input  wire [15:0] EXT_I,
	input  wire [15:0] FLAGS_I,
	input  wire [15:0] STACK_PTR_I,
	input  wire [15:0] CS_I,
	input  wire [15:0] INSTR_PTR_I,
	input  wire        IO_ACK_I,
	input  wire [15:0] IO_DATA_I,
	input  wire        MEM_ACK_I,
	input  wire [15:0] MEM_RDATA_I,
	output reg         BUSY_O,
	output reg         DONE_O,
	output reg         ACC_WE_O,
	output reg  [1:0]  ACC_BE_O,
	output reg  [15:0] ACC_O,
	output reg         EXT_WE_O,
	output reg  [15:0] EXT_O,
	output reg         FLAGS_WE_O,
	output reg  [15:0] FLAGS_O,
	output reg         STACK_PTR_WE_O,
	output reg  [15:0] STACK_PTR_O,
	output reg         CS_WE_O,
	output reg  [15:0] CS_O,
	output reg         INSTR_PTR_WE_O,
	output reg  [15:0] INSTR_PTR_O,
	output reg         IO_RD_O,
	output reg  [15:0] IO_ADDR_O,
	output reg         IO_WORD_O,
	output reg         MEM_RD_O,
	output reg         MEM_WR_O,
	output reg  [15:0] MEM_ADDR_O,
	output reg  [15:0] MEM_WDATA_O
);
	// ****************************************************************
	// States.
	// ****************************************************************
	localparam ST_IDLE  = 4'h0;
	localparam ST_DIV   = 4'h1;
	localparam ST_IN    = 4'h2;
	localparam ST_PFL   = 4'h3;
	localparam ST_PCS   = 4'h4;
	localparam ST_LCS   = 4'h5;
	localparam ST_PIP   = 4'h6;
	localparam ST_LIP   = 4'h7;
	localparam ST_WAIT  = 4'h8;
	reg  [3:0]  state;
	reg         word;
	reg         neg_q;
	reg         neg_r;
	reg  [15:0] stk;
	reg  [15:0] cs_sv;
	reg  [15:0] ptr_sv;
	reg  [15:0] fl_sv;
	reg  [3:0]  after_wr;
	reg         div_go;
	// ****************************************************************
	// Operand magnitudes and products.
	// ****************************************************************
	wire [31:0] dvd_s;
	wire [15:0] dvs_s;
	wire [31:0] dvd_mag;
	wire [15:0] dvs_mag;
	wire [31:0] prod_b;
	wire [31:0] prod_w;
	wire        sig_b;
	wire        sig_w;
	wire        div_done;
	wire [31:0] uq;
	wire [16:0] ur;
	wire [31:0] q_s;
	wire [15:0] r_s;
	wire        q_bad;
	assign dvd_s   = word ? {EXT_I, ACC_I} : {{16{ACC_I[15]}}, ACC_I};
	assign dvs_s   = word ? SRC_I : {{8{SRC_I[7]}}, SRC_I[7:0]};
	assign dvd_mag = dvd_s[31] ? (32'h00000000 - dvd_s) : dvd_s;
	assign dvs_mag = dvs_s[15] ? (16'h0000 - dvs_s) : dvs_s;
	assign prod_b  = {{16{SRC_I[7]}}, {{8{SRC_I[7]}}, SRC_I[7:0]}}
		* {{24{ACC_I[7]}}, ACC_I[7:0]};
	assign prod_w  = {{16{SRC_I[15]}}, SRC_I} * {{16{ACC_I[15]}}, ACC_I};
	assign sig_b   = prod_b[15:8] != {8{prod_b[7]}};
	assign sig_w   = prod_w[31:16] != {16{prod_w[15]}};
	assign q_s     = neg_q ? (32'h00000000 - uq) : uq;
	assign r_s     = neg_r ? (16'h0000 - ur[15:0]) : ur[15:0];
	assign q_bad   = word ? (uq > 32'h00007fff) : (uq > 32'h0000007f);
	smdpi_udiv u_div
	(
		.clk_i      (CLK_I),
		.reset_n_i  (RESET_N_I),
		.start_i    (div_go),
		.dividend_i (dvd_mag),
		.divisor_i  (dvs_mag),
		.done_o     (div_done),
		.quot_o     (uq),
		.rem_o      (ur)
	);
	// ****************************************************************
	// Sequencer.
	// ****************************************************************
	always @(posedge CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			state <= ST_IDLE; word <= 1'b0; neg_q <= 1'b0; neg_r <= 1'b0;
			stk <= `SMDPI_RESET_WORD; cs_sv <= `SMDPI_RESET_WORD;
			ptr_sv <= `SMDPI_RESET_WORD; fl_sv <= `SMDPI_RESET_WORD;
			after_wr <= ST_IDLE; div_go <= 1'b0;
			BUSY_O <= 1'b0; DONE_O <= 1'b0;
			ACC_WE_O <= 1'b0; ACC_BE_O <= 2'h0; ACC_O <= `SMDPI_RESET_WORD;
			EXT_WE_O <= 1'b0; EXT_O <= `SMDPI_RESET_WORD;
			FLAGS_WE_O <= 1'b0; FLAGS_O <= `SMDPI_RESET_WORD;
			STACK_PTR_WE_O <= 1'b0; STACK_PTR_O <= `SMDPI_RESET_WORD;
			CS_WE_O <= 1'b0; CS_O <= `SMDPI_RESET_WORD;
			INSTR_PTR_WE_O <= 1'b0; INSTR_PTR_O <= `SMDPI_RESET_WORD;
			IO_RD_O <= 1'b0; IO_ADDR_O <= `SMDPI_RESET_WORD; IO_WORD_O <= 1'b0;
			MEM_RD_O <= 1'b0; MEM_WR_O <= 1'b0;
			MEM_ADDR_O <= `SMDPI_RESET_WORD; MEM_WDATA_O <= `SMDPI_RESET_WORD;
		end
		else
		begin
			DONE_O <= 1'b0; ACC_WE_O <= 1'b0; EXT_WE_O <= 1'b0;
			FLAGS_WE_O <= 1'b0; STACK_PTR_WE_O <= 1'b0; CS_WE_O <= 1'b0;
			INSTR_PTR_WE_O <= 1'b0; div_go <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					if (START_I)
					begin
						word <= WORD_I;
						BUSY_O <= 1'b1;
						case (OP_I)
							`SMDPI_OP_MUL:
							begin
								ACC_WE_O <= 1'b1;
								ACC_BE_O <= 2'h3;
								ACC_O <= WORD_I ? prod_w[15:0] : prod_b[15:0];
								EXT_WE_O <= WORD_I;
								EXT_O <= prod_w[31:16];
								FLAGS_WE_O <= 1'b1;
								FLAGS_O <= FLAGS_I;
								FLAGS_O[`SMDPI_FLAG_CARRY] <= WORD_I ? sig_w : sig_b;
								FLAGS_O[`SMDPI_FLAG_OVFL] <= WORD_I ? sig_w : sig_b;
								DONE_O <= 1'b1;
								BUSY_O <= 1'b0;
							end
							`SMDPI_OP_DIV:
							begin
								neg_q <= (WORD_I ? EXT_I[15] : ACC_I[15])
									^ (WORD_I ? SRC_I[15] : SRC_I[7]);
								neg_r <= WORD_I ? EXT_I[15] : ACC_I[15];
								fl_sv <= FLAGS_I;
								stk <= STACK_PTR_I; cs_sv <= CS_I; ptr_sv <= INSTR_PTR_I;
								if (WORD_I ? (SRC_I == 16'h0000) : (SRC_I[7:0] == 8'h00))
									state <= ST_PFL;
								else
								begin
									div_go <= 1'b1;
									state <= ST_DIV;
								end
							end
							`SMDPI_OP_IN:
							begin
								IO_RD_O <= 1'b1;
								IO_WORD_O <= WORD_I;
								IO_ADDR_O <= PORT_IMM_I ? {8'h00, PORT_IMM8_I} : EXT_I;
								state <= ST_IN;
							end
							default:
							begin
								DONE_O <= 1'b1;
								BUSY_O <= 1'b0;
							end
						endcase
					end
				end
				ST_DIV:
				begin
					if (div_done)
					begin
						if (q_bad)
							state <= ST_PFL;
						else
						begin
							ACC_WE_O <= 1'b1;
							EXT_WE_O <= word;
							ACC_BE_O <= word ? 2'h3 : 2'h3;
							ACC_O <= word ? q_s[15:0] : {r_s[7:0], q_s[7:0]};
							EXT_O <= r_s;
							DONE_O <= 1'b1;
							BUSY_O <= 1'b0;
							state <= ST_IDLE;
						end
					end
				end
				ST_IN:
				begin
					if (IO_ACK_I)
					begin
						IO_RD_O <= 1'b0;
						ACC_WE_O <= 1'b1;
						ACC_BE_O <= word ? 2'h3 : 2'h1;
						ACC_O <= word ? IO_DATA_I : {ACC_I[15:8], IO_DATA_I[7:0]};
						DONE_O <= 1'b1;
						BUSY_O <= 1'b0;
						state <= ST_IDLE;
					end
				end
				ST_PFL:
				begin
					stk <= stk - `SMDPI_STACK_STEP;
					MEM_WR_O <= 1'b1;
					MEM_ADDR_O <= stk - `SMDPI_STACK_STEP;
					MEM_WDATA_O <= fl_sv;
					FLAGS_WE_O <= 1'b1;
					FLAGS_O <= fl_sv;
					FLAGS_O[`SMDPI_FLAG_IF] <= 1'b0;
					FLAGS_O[`SMDPI_FLAG_TRAP] <= 1'b0;
					after_wr <= ST_PCS;
					state <= ST_WAIT;
				end
				ST_PCS:
				begin
					stk <= stk - `SMDPI_STACK_STEP;
					MEM_WR_O <= 1'b1;
					MEM_ADDR_O <= stk - `SMDPI_STACK_STEP;
					MEM_WDATA_O <= cs_sv;
					after_wr <= ST_LCS;
					state <= ST_WAIT;
				end
				ST_LCS:
				begin
					MEM_RD_O <= 1'b1;
					MEM_ADDR_O <= `SMDPI_VEC_CS;
					after_wr <= ST_PIP;
					state <= ST_WAIT;
				end
				ST_PIP:
				begin
					stk <= stk - `SMDPI_STACK_STEP;
					MEM_WR_O <= 1'b1;
					MEM_ADDR_O <= stk - `SMDPI_STACK_STEP;
					MEM_WDATA_O <= ptr_sv;
					after_wr <= ST_LIP;
					state <= ST_WAIT;
				end
				ST_LIP:
				begin
					MEM_RD_O <= 1'b1;
					MEM_ADDR_O <= `SMDPI_VEC_PTR;
					after_wr <= ST_IDLE;
					state <= ST_WAIT;
				end
				ST_WAIT:
				begin
					if (MEM_ACK_I)
					begin
						MEM_RD_O <= 1'b0;
						MEM_WR_O <= 1'b0;
						state <= after_wr;
						if (after_wr == ST_PIP)
						begin
							CS_WE_O <= 1'b1;
							CS_O <= MEM_RDATA_I;
						end
						if (after_wr == ST_LIP)
						begin
							STACK_PTR_WE_O <= 1'b1;
							STACK_PTR_O <= stk;
						end
						if (after_wr == ST_IDLE)
						begin
							INSTR_PTR_WE_O <= 1'b1;
							INSTR_PTR_O <= MEM_RDATA_I;
							DONE_O <= 1'b1;
							BUSY_O <= 1'b0;
						end
					end
				end
				default:
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule // smdpi_core

// ===== hdl/smdpi_defines.vh
// Operation
// - Byte divide: accumulator word in, quotient low, remainder high.
// - Byte quotient valid only from 81H to 7FH.
// - Word divide: extension and accumulator words in.
// - Word quotient valid only from 8001H to 7FFFH.
// - Out of range: no result write, raise type 0.
// - Zero divisor always raises type 0 exception.
// - Quotient truncates toward zero, remainder follows dividend.
// - Exception pushes state, clears interrupt and trap flags.
// - Divide without exception keeps direction, interrupt-enable and trap flags.
// - Byte multiply: low byte times source into accumulator.
// - Word multiply: product into extension and accumulator.
// - Multiply sets carry and overflow when upper significant.
// - Port input loads low byte or whole accumulator.
// - Immediate byte port number addresses ports 0-255.
// - Extension word port number addresses ports 0-65535.
`ifndef SMDPI_DEFINES_VH
`define SMDPI_DEFINES_VH
// ****************************************************************
// Operation codes.
// ****************************************************************
`define SMDPI_OP_DIV 2'h0
`define SMDPI_OP_MUL 2'h1
`define SMDPI_OP_IN 2'h2
// ****************************************************************
// Flag bit positions.
// ****************************************************************
`define SMDPI_FLAG_CARRY 0
`define SMDPI_FLAG_TRAP 8
`define SMDPI_FLAG_IF 9
`define SMDPI_FLAG_OVFL 11
// ****************************************************************
// Exception vector word addresses and stack step.
// ****************************************************************
`define SMDPI_VEC_PTR 16'h0000
`define SMDPI_VEC_CS 16'h0002
`define SMDPI_STACK_STEP 16'h0002
`define SMDPI_RESET_WORD 16'h0000
// ****************************************************************
// Divider iteration count.
// ****************************************************************
`define SMDPI_DIV_STEPS 6'h20
`endif

// ===== hdl/smdpi_udiv.v
`timescale 1ns/1ps
`include "smdpi_defines.vh"
// ****************************************************************
// Restoring unsigned divider, one quotient bit per clock.
// ****************************************************************
module smdpi_udiv
(
	input  wire        clk_i,
	input  wire        reset_n_i,
	input  wire        start_i,
	input  wire [31:0] dividend_i,
	input  wire [15:0] divisor_i,
	output reg         done_o,
	output reg  [31:0] quot_o,
	output reg  [16:0] rem_o
);
	reg  [5:0]  count;
	reg         busy;
	reg  [15:0] dvs;
	wire [16:0] trial;
	assign trial = {rem_o[15:0], quot_o[31]} - {1'b0, dvs};
	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			count  <= 6'h00;
			busy   <= 1'b0;
			dvs    <= 16'h0000;
			done_o <= 1'b0;
			quot_o <= 32'h00000000;
			rem_o  <= 17'h00000;
		end
		else
		begin
			done_o <= 1'b0;
			if (start_i)
			begin
				busy   <= 1'b1;
				count  <= `SMDPI_DIV_STEPS;
				dvs    <= divisor_i;
				quot_o <= dividend_i;
				rem_o  <= 17'h00000;
			end
			else if (busy)
			begin
				if (!trial[16])
				begin
					rem_o  <= trial;
					quot_o <= {quot_o[30:0], 1'b1};
				end
				else
				begin
					rem_o  <= {rem_o[15:0], quot_o[31]};
					quot_o <= {quot_o[30:0], 1'b0};
				end
				count <= count - 6'h01;
				if (count == 6'h01)
				begin
					busy   <= 1'b0;
					done_o <= 1'b1;
				end
			end
		end
	end
endmodule // smdpi_udiv

// ===== sim/smdpi_chk_properties.sv
`timescale 1ns/1ps
`include "smdpi_defines.vh"
// ****************************************************************
// Port checker for the datapath core.
// ****************************************************************
module smdpi_chk
(
	input wire        CLK_I,
	input wire        RESET_N_I,
	input wire        START_I,
	input wire [1:0]  OP_I,
	input wire        WORD_I,
	input wire        PORT_IMM_I,
	input wire [7:0]  PORT_IMM8_I,
	input wire [15:0] SRC_I,
	input wire [15:0] ACC_I,
	input wire [15:0] EXT_I,
	input wire        IO_ACK_I,
	input wire [15:0] IO_DATA_I,
	input wire [15:0] MEM_RDATA_I,
	input wire        BUSY_O,
	input wire        DONE_O,
	input wire        ACC_WE_O,
	input wire [15:0] ACC_O,
	input wire        EXT_WE_O,
	input wire [15:0] EXT_O,
	input wire        FLAGS_WE_O,
	input wire [15:0] FLAGS_O,
	input wire        CS_WE_O,
	input wire [15:0] CS_O,
	input wire        INSTR_PTR_WE_O,
	input wire        IO_RD_O,
	input wire [15:0] IO_ADDR_O,
	input wire        MEM_WR_O,
	input wire [15:0] MEM_ADDR_O
);
	wire               st  = START_I && !BUSY_O;
	wire               mul = st && OP_I == `SMDPI_OP_MUL;
	wire               dz  = st && OP_I == `SMDPI_OP_DIV && SRC_I[7:0] == 8'h00
	                         && (!WORD_I || SRC_I[15:8] == 8'h00);
	wire signed [15:0] pb  = $signed(SRC_I[7:0]) * $signed(ACC_I[7:0]);
	wire signed [31:0] pw  = $signed(SRC_I) * $signed(ACC_I);
	wire               ov  = WORD_I ? pw[31:16] != {16{pw[15]}} : pb[15:8] != {8{pb[7]}};
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RESET_N_I);
	AST_MUL_DONE: assert property (mul |=> DONE_O && ACC_WE_O)
		else $error("multiply late");
	AST_MUL_BYTE: assert property (mul && !WORD_I |=> ACC_O == $past(pb))
		else $error("byte product wrong");
	AST_MUL_WORD: assert property (
		mul && WORD_I |=> EXT_WE_O && {EXT_O, ACC_O} == $past(pw))
		else $error("word product wrong");
	AST_MUL_FLAGS: assert property (
		mul |=> FLAGS_WE_O && FLAGS_O[`SMDPI_FLAG_CARRY] == $past(ov)
		&& FLAGS_O[`SMDPI_FLAG_OVFL] == $past(ov))
		else $error("multiply flags wrong");
	AST_DIV_ZERO: assert property (
		dz |=> (!ACC_WE_O && !EXT_WE_O) throughout (##[0:60] MEM_WR_O))
		else $error("zero divisor not trapped");
	AST_EXC_FLAGS: assert property (
		FLAGS_WE_O && !DONE_O |-> !FLAGS_O[`SMDPI_FLAG_TRAP] && !FLAGS_O[`SMDPI_FLAG_IF])
		else $error("trap flags kept");
	AST_EXC_CS: assert property (
		CS_WE_O |-> $past(MEM_ADDR_O) == `SMDPI_VEC_CS && CS_O == $past(MEM_RDATA_I))
		else $error("segment vector wrong");
	AST_EXC_END: assert property (
		INSTR_PTR_WE_O |-> DONE_O && $past(MEM_ADDR_O) == `SMDPI_VEC_PTR)
		else $error("pointer vector wrong");
	AST_IN_ADDR: assert property (
		$rose(IO_RD_O) |-> IO_ADDR_O == (PORT_IMM_I ? {8'h00, PORT_IMM8_I} : EXT_I))
		else $error("port address wrong");
	AST_IN_DATA: assert property (
		IO_RD_O && IO_ACK_I |=> ACC_WE_O && !FLAGS_WE_O && ACC_O[7:0] == $past(IO_DATA_I[7:0]))
		else $error("port data wrong");
endmodule // smdpi_chk
bind smdpi_core smdpi_chk u_chk (.*);

// ===== sim/smdpi_partner.sv
`timescale 1ns/1ps
// ****************************************************************
// Memory and port bus model with random wait states.
// ****************************************************************
module smdpi_partner
#(
	parameter [15:0] P_PTR = 16'h0000,
	parameter [15:0] P_CS = 16'h0000
)
(
	input  wire        clk_i,
	input  wire        io_rd_i,
	input  wire [15:0] io_addr_i,
	input  wire        mem_rd_i,
	input  wire        mem_wr_i,
	input  wire [15:0] mem_addr_i,
	input  wire [15:0] mem_wdata_i,
	output reg         io_ack_o,
	output reg  [15:0] io_data_o,
	output reg         mem_ack_o,
	output reg  [15:0] mem_rdata_o
);
	reg  [15:0] mem [0:65535];
	reg  [1:0]  wait_n;
	wire        req = (io_rd_i || mem_rd_i || mem_wr_i) && !io_ack_o && !mem_ack_o;
	initial
	begin
		{io_ack_o, mem_ack_o, io_data_o, mem_rdata_o, wait_n} = '0;
		mem[16'h0000] = P_PTR;
		mem[16'h0002] = P_CS;
	end
	always @(negedge clk_i)
	begin
		io_ack_o <= 1'b0;
		mem_ack_o <= 1'b0;
		io_data_o <= ~io_data_o;
		mem_rdata_o <= ~mem_rdata_o;
		if (req && wait_n != 2'h0)
			wait_n <= wait_n - 2'h1;
		else if (req)
		begin
			wait_n <= 2'($urandom);
			io_ack_o <= io_rd_i;
			mem_ack_o <= !io_rd_i;
			io_data_o <= ~{io_addr_i[7:0], io_addr_i[15:8]};
			mem_rdata_o <= mem[mem_addr_i];
			if (mem_wr_i)
				mem[mem_addr_i] <= mem_wdata_i;
		end
	end
endmodule // smdpi_partner

// ===== sim/signed_muldiv_port_input_tb.sv
`timescale 1ns/1ps
`include "smdpi_defines.vh"
// ****************************************************************
// Bench for the datapath core.
// ****************************************************************
module signed_muldiv_port_input_tb;
	localparam [15:0] VIP = 16'h1a2b;
	localparam [15:0] VCS = 16'h3c4d;
	localparam [1:0]  DV  = `SMDPI_OP_DIV;
	localparam [1:0]  ML  = `SMDPI_OP_MUL;
	reg         CLK_I, RESET_N_I, START_I, WORD_I, PORT_IMM_I;
	reg  [1:0]  OP_I;
	reg  [7:0]  PORT_IMM8_I;
	reg  [15:0] SRC_I, ACC_I, EXT_I, FLAGS_I, STACK_PTR_I, CS_I, INSTR_PTR_I;
	wire        IO_ACK_I, MEM_ACK_I, BUSY_O, DONE_O, ACC_WE_O, EXT_WE_O, FLAGS_WE_O;
	wire        STACK_PTR_WE_O, CS_WE_O, INSTR_PTR_WE_O, IO_RD_O, IO_WORD_O;
	wire        MEM_RD_O, MEM_WR_O;
	wire [1:0]  ACC_BE_O;
	wire [15:0] IO_DATA_I, MEM_RDATA_I, ACC_O, EXT_O, FLAGS_O, STACK_PTR_O, CS_O;
	wire [15:0] INSTR_PTR_O;
	wire [15:0] IO_ADDR_O, MEM_ADDR_O, MEM_WDATA_O;
	reg  [15:0] g_acc, g_ext, g_fl, g_sp, g_cs, g_ip;
	reg  [1:0]  g_be;
	reg  [5:0]  g_we;
	integer     n_mismatch, num_checks, i;
	smdpi_core u_dut (.*);
	smdpi_partner #(.P_PTR(VIP), .P_CS(VCS)) u_mem (.clk_i(CLK_I), .io_rd_i(IO_RD_O),
		.io_addr_i(IO_ADDR_O), .mem_rd_i(MEM_RD_O), .mem_wr_i(MEM_WR_O),
		.mem_addr_i(MEM_ADDR_O), .mem_wdata_i(MEM_WDATA_O), .io_ack_o(IO_ACK_I),
		.io_data_o(IO_DATA_I), .mem_ack_o(MEM_ACK_I), .mem_rdata_o(MEM_RDATA_I));
	task chk(input string nm, input [47:0] s, input [47:0] x);
		num_checks = num_checks + 1;
		if (s !== x)
		begin
			n_mismatch = n_mismatch + 1;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask
	task results;
		if (n_mismatch == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function [32:0] dexp(input w, input [15:0] s, a, x);
		longint n, d, q, r;
		n = w ? $signed({x, a}) : $signed(a);
		d = w ? $signed(s) : $signed(s[7:0]);
		q = (d == 0) ? 0 : n / d;
		r = (d == 0) ? 0 : n % d;
		dexp = {d == 0 || q > (w ? 32767 : 127) || q < (w ? -32767 : -127), r[15:0], q[15:0]};
	endfunction
	task run(input [1:0] o, input w, input pm, input [7:0] p8, input [15:0] s, a, x);
		integer           k;
		reg signed [31:0] pr;
		reg        [32:0] e;
		reg        [15:0] pa;
		@(negedge CLK_I);
		{OP_I, WORD_I, PORT_IMM_I, PORT_IMM8_I, SRC_I, ACC_I, EXT_I} = {o, w, pm, p8, s, a, x};
		FLAGS_I = 16'($urandom);
		CS_I = 16'($urandom);
		INSTR_PTR_I = 16'($urandom);
		STACK_PTR_I = 16'h8000 | 16'($urandom & 32'h7ffe);
		START_I = 1'b1;
		g_we = 6'h00;
		{g_acc, g_ext, g_fl, g_sp, g_cs, g_ip} = {96{1'bx}};
		k = 0;
		do
		begin
			@(negedge CLK_I);
			START_I = 1'b0;
			g_we = g_we | {INSTR_PTR_WE_O, CS_WE_O, STACK_PTR_WE_O, FLAGS_WE_O, EXT_WE_O,
				ACC_WE_O};
			if (ACC_WE_O === 1'b1)
				{g_acc, g_be} = {ACC_O, ACC_BE_O};
			if (EXT_WE_O === 1'b1)
				g_ext = EXT_O;
			if (FLAGS_WE_O === 1'b1)
				g_fl = FLAGS_O;
			if (STACK_PTR_WE_O === 1'b1)
				g_sp = STACK_PTR_O;
			if (CS_WE_O === 1'b1)
				g_cs = CS_O;
			if (INSTR_PTR_WE_O === 1'b1)
				g_ip = INSTR_PTR_O;
			k = k + 1;
		end
		while (DONE_O !== 1'b1 && k < 400);
		chk("done", k < 400, 1'b1);
		e = dexp(w, s, a, x);
		pr = w ? $signed(s) * $signed(a) : $signed(s[7:0]) * $signed(a[7:0]);
		pa = pm ? {8'h00, p8} : x;
		if (o == DV && e[32])
		begin
			chk("div_we", g_we[1:0], 2'h0);
			chk("exc_regs", {g_sp, g_cs, g_ip}, {STACK_PTR_I - 16'h0006, VCS, VIP});
			chk("exc_fl", g_fl, FLAGS_I & 16'hfcff);
			chk("push_fl", u_mem.mem[STACK_PTR_I - 16'h0002], FLAGS_I);
			chk("push_cs", u_mem.mem[STACK_PTR_I - 16'h0004], CS_I);
			chk("push_ptr", u_mem.mem[STACK_PTR_I - 16'h0006], INSTR_PTR_I);
		end
		else if (o == DV)
			chk("div", {g_we[2], g_ext & {16{w}}, g_acc}, {1'b0, w ? e[31:0] : {16'h0, e[23:16], e[7:0]}});
		else if (o == ML)
		begin
			chk("mul", {g_acc, g_ext & {16{w}}}, {pr[15:0], pr[31:16] & {16{w}}});
			chk("mul_fl", {g_fl[`SMDPI_FLAG_OVFL], g_fl[`SMDPI_FLAG_CARRY]},
				{2{w ? pr[31:16] !== {16{pr[15]}} : pr[15:8] !== {8{pr[7]}}}});
		end
		else if (o == `SMDPI_OP_IN)
			chk("in", {g_we[2], g_be, g_acc & {{8{w}}, 8'hff}}, {1'b0, w ? 2'h3 : 2'h1, ~{pa[7:0], pa[15:8]} & {{8{w}}, 8'hff}});
	endtask
	task c(input [1:0] o, input w, input [47:0] v);
		run(o, w, 1'b0, 8'h00, v[47:32], v[31:16], v[15:0]);
	endtask
	initial
	begin
		CLK_I = 1'b0;
		forever #2.5 CLK_I = ~CLK_I;
	end
	initial
	begin
		#400000;
		n_mismatch = n_mismatch + 1;
		results;
	end
	initial
	begin
		{n_mismatch, num_checks} = '0;
		{START_I, OP_I, WORD_I, PORT_IMM_I, PORT_IMM8_I, SRC_I, ACC_I} = '0;
		{EXT_I, FLAGS_I, STACK_PTR_I, CS_I, INSTR_PTR_I} = '0;
		RESET_N_I = 1'b0;
		i = $urandom(56);
		repeat (20) @(negedge CLK_I);
		RESET_N_I = 1'b1;
		c(DV, 1'b0, 48'h0001_007f_0000);
		c(DV, 1'b0, 48'h0001_0080_0000);
		c(DV, 1'b0, 48'h00ff_ff81_0000);
		c(DV, 1'b0, 48'h0001_ff80_0000);
		c(DV, 1'b0, 48'h0002_fff9_0000);
		c(DV, 1'b0, 48'hff00_1234_0000);
		c(DV, 1'b1, 48'h0001_7fff_0000);
		c(DV, 1'b1, 48'hffff_8001_0000);
		c(DV, 1'b1, 48'h0001_8000_ffff);
		c(DV, 1'b1, 48'h0002_fff9_ffff);
		c(DV, 1'b1, 48'h0000_1234_0000);
		c(DV, 1'b0, 48'h1200_0100_0000);
		c(DV, 1'b1, 48'h1200_0100_0000);
		c(ML, 1'b0, 48'h0080_0080_0000);
		c(ML, 1'b1, 48'h8000_8000_0000);
		run(`SMDPI_OP_IN, 1'b1, 1'b0, 8'h00, 16'h0000, 16'h0000, 16'hfedc);
		run(`SMDPI_OP_IN, 1'b0, 1'b1, 8'hff, 16'h0000, 16'h0000, 16'hfedc);
		for (i = 0; i < 150; i = i + 1)
			run(2'($urandom), 1'($urandom), 1'($urandom), 8'($urandom), 16'($urandom),
				16'($urandom), 16'($urandom & 32'h00ff));
		results;
	end
endmodule // signed_muldiv_port_input_tb
